// *** hw/swds_map.svh ***
// Contract
// - host starts every bit with falling edge
// - msb first, sixteen cycles per bit
// - 512 idle cycles abandon, clear command
// - synchronise host edge to bus clock
// - target samples host bit at cycle ten
// - target leaves line undriven on host bits
// - pseudo open drain, only brief high drive
// - host holds start low two cycles minimum
// - one: speed-up pulse at cycle seven
// - zero: low thirteen cycles, then high pulse
// - host samples about ten cycles after edge
// - bus access in dead cycles, steal if needed
// - firmware commands only in background mode
// - eight-bit opcode, then address and/or data
`ifndef SWDS_MAP_SVH
`define SWDS_MAP_SVH
// bit timing in bus clock cycles, opcode and word lengths in bits
`define SWDS_BIT_CYC 5'h10
`define SWDS_SYNC_LAT 5'h02
`define SWDS_RX_SAMPLE 5'h0a
`define SWDS_ONE_PULSE 5'h07
`define SWDS_ZERO_LOW 5'h0d
`define SWDS_TMO_CYC 10'h200
`define SWDS_OPC_BITS 5'h08
`define SWDS_WORD_BITS 5'h10
// host side timing
`define SWDS_H_ONE_LOW 8'h04
`define SWDS_H_ZERO_LOW 8'h0e
`define SWDS_H_RX_LOW 8'h03
`define SWDS_H_SAMPLE 8'h0c
`define SWDS_H_WAIT 8'h96
// bus arbitration
`define SWDS_STEAL_CYC 8'h80
// opcode fields
`define SWDS_OP_BG 8'h90
`define SWDS_OP_HW 7
`define SWDS_OP_ADDR 6
`define SWDS_OP_READ 5
// request queue
`define SWDS_Q_DEPTH 16
`define SWDS_Q_WIDTH 40
`endif

// *** hw/swds_pkg.sv ***
package swds_pkg;
   typedef logic [7:0] swds_op_t;
   typedef logic [15:0] swds_word_t;
   // command phase of the serial exchange
   typedef enum logic [2:0] {
      PH_OPC = 3'h0,
      PH_ADDR = 3'h1,
      PH_WDAT = 3'h2,
      PH_RDAT = 3'h3,
      PH_PUSH = 3'h4
   } swds_phase_t;
   typedef enum logic [1:0] {
      B_IDLE = 2'h0,
      B_RX = 2'h1,
      B_TX = 2'h2
   } swds_bit_t;
   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_TX = 3'h1,
      H_WAIT = 3'h2,
      H_RX = 3'h3,
      H_GAP = 3'h4
   } swds_host_t;
endpackage

// *** hw/swds_if.sv ***
`timescale 1ns/1ps
interface swds_if;
   logic tgt_out;
   logic tgt_oe_n;
   logic host_out;
   logic host_oe_n;
   logic line;
   // wired line with pull-up: any low drive wins, high drive only speeds the edge
   assign line = ~((~tgt_oe_n & ~tgt_out) | (~host_oe_n & ~host_out));
   modport tgt (input line, output tgt_out, output tgt_oe_n);
   modport host (input line, output host_out, output host_oe_n);
endinterface

// *** hw/swds_fifo.sv ***
`timescale 1ns/1ps
module swds_fifo #(
   parameter int W = 40,
   parameter int D = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [W-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [W-1:0] o_out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } swds_fifo_t;
   swds_fifo_t r_ff;
   swds_fifo_t nxt_r;
   logic push;
   logic pop;
   // honest flags straight from the count
   assign o_in_ready = (r_ff.cnt != D[AW:0]);
   assign o_out_valid = (r_ff.cnt != '0);
   assign o_out_data = r_ff.mem[r_ff.rd];
   assign push = i_in_valid & o_in_ready;
   assign pop = o_out_valid & i_out_ready;
   // pointers wrap because depth is a power of two
   always_comb begin
      nxt_r = r_ff;
      if (push) begin
         nxt_r.mem[r_ff.wr] = i_in_data;
         nxt_r.wr = r_ff.wr + 1'b1;
      end
      if (pop) begin
         nxt_r.rd = r_ff.rd + 1'b1;
      end
      nxt_r.cnt = r_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end
endmodule // swds_fifo

// *** hw/swds_target.sv ***
`timescale 1ns/1ps
`include "swds_map.svh"
module swds_target (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   swds_if.tgt LINK,
   input wire logic I_BG_ACTIVE,
   input wire logic I_FW_EN,
   input wire logic I_DEAD_CYCLE,
   input wire logic I_BUS_ACK,
   input wire logic I_RD_VALID,
   input wire swds_pkg::swds_word_t I_RD_DATA,
   output logic O_BUS_REQ,
   output logic O_BUS_STEAL,
   output swds_pkg::swds_op_t O_BUS_OP,
   output swds_pkg::swds_word_t O_BUS_ADDR,
   output swds_pkg::swds_word_t O_BUS_DATA,
   output logic O_ENTER_BG,
   output logic O_ROM_MAP
);
   import swds_pkg::*;

   typedef struct packed {
      logic [2:0] sync;
      swds_bit_t bit_st;
      logic [4:0] cyc;
      logic [9:0] tmo;
      swds_phase_t phase;
      swds_phase_t after;
      logic [4:0] nbits;
      swds_word_t shift;
      swds_op_t op;
      swds_word_t addr;
      swds_word_t tx;
      swds_word_t rd;
      logic tx_bit;
      logic out;
      logic oe_n;
      logic enter_bg;
      logic [7:0] wait_cnt;
      logic rom_map;
   } swds_tgt_t;

   swds_tgt_t r_ff;
   swds_tgt_t nxt_r;
   logic fall;
   logic accept;
   logic busy;
   logic bit_done;
   logic [4:0] need;
   logic q_in_ready;
   logic q_out_valid;
   logic q_out_ready;
   logic steal;
   logic [`SWDS_Q_WIDTH-1:0] q_out_data;

   // opcode classes, used only at opcode decode
   function automatic logic is_mem_cmd(input swds_op_t op);
      return op[`SWDS_OP_HW] & op[`SWDS_OP_ADDR];
   endfunction

   function automatic logic is_fw_cmd(input swds_op_t op);
      return ~op[`SWDS_OP_HW];
   endfunction

   // only the second and third stage feed the edge detector
   assign fall = r_ff.sync[2] & ~r_ff.sync[1];
   // no new bit while a bit runs or a request waits for room
   assign accept = fall & (r_ff.bit_st == B_IDLE) & (r_ff.phase != PH_PUSH);
   assign busy = (r_ff.bit_st != B_IDLE) || (r_ff.nbits != 5'h00)
      || (r_ff.phase != PH_OPC && r_ff.phase != PH_PUSH);
   assign need = (r_ff.phase == PH_OPC) ? `SWDS_OPC_BITS : `SWDS_WORD_BITS;

   always_comb begin
      nxt_r = r_ff;
      bit_done = 1'b0;
      nxt_r.sync = {r_ff.sync[1:0], LINK.line};
      nxt_r.enter_bg = 1'b0;
      nxt_r.rom_map = I_BG_ACTIVE;
      // read data may come back any time before the host clocks it out
      if (I_RD_VALID) begin
         nxt_r.rd = I_RD_DATA;
      end

      // bit engine: count from the perceived start of each bit
      unique case (r_ff.bit_st)
         B_IDLE: begin
            if (accept) begin
               // sync and edge flops already cost two cycles of this bit; counting
               // from there keeps a zero's release clear of the next host edge
               nxt_r.cyc = `SWDS_SYNC_LAT;
               if (r_ff.phase == PH_RDAT) begin
                  // first bit of a read word takes the fetched data
                  nxt_r.tx = (r_ff.nbits == 5'h00) ? r_ff.rd : r_ff.tx;
                  nxt_r.tx_bit = nxt_r.tx[15];
                  nxt_r.tx = {nxt_r.tx[14:0], 1'b0};
                  nxt_r.bit_st = B_TX;
               end else begin
                  nxt_r.bit_st = B_RX;
               end
            end
         end
         B_RX: begin
            nxt_r.cyc = r_ff.cyc + 5'h01;
            if (r_ff.cyc == `SWDS_RX_SAMPLE) begin
               nxt_r.shift = {r_ff.shift[14:0], r_ff.sync[1]};
               nxt_r.nbits = r_ff.nbits + 5'h01;
               nxt_r.bit_st = B_IDLE;
               bit_done = 1'b1;
            end
         end
         B_TX: begin
            nxt_r.cyc = r_ff.cyc + 5'h01;
            // drive window ends after the zero's speed-up cycle
            if (r_ff.cyc == `SWDS_ZERO_LOW) begin
               nxt_r.nbits = r_ff.nbits + 5'h01;
               nxt_r.bit_st = B_IDLE;
               bit_done = 1'b1;
            end
         end
         default: begin
            nxt_r.bit_st = B_IDLE;
         end
      endcase

      // word complete: decode and step the command phase
      if (bit_done && nxt_r.nbits == need) begin
         nxt_r.nbits = 5'h00;
         unique case (r_ff.phase)
            PH_OPC: begin
               nxt_r.op = nxt_r.shift[7:0];
               nxt_r.phase = PH_OPC;
               if (nxt_r.shift[7:0] == `SWDS_OP_BG) begin
                  nxt_r.enter_bg = I_FW_EN;
               end else if (is_mem_cmd(nxt_r.shift[7:0])) begin
                  nxt_r.phase = PH_ADDR;
               end else if (is_fw_cmd(nxt_r.shift[7:0]) && I_BG_ACTIVE) begin
                  nxt_r.phase = PH_PUSH;
                  nxt_r.after = PH_RDAT;
               end
            end
            PH_ADDR: begin
               nxt_r.addr = nxt_r.shift;
               if (r_ff.op[`SWDS_OP_READ]) begin
                  nxt_r.phase = PH_PUSH;
                  nxt_r.after = PH_RDAT;
               end else begin
                  nxt_r.phase = PH_WDAT;
               end
            end
            PH_WDAT: begin
               nxt_r.phase = PH_PUSH;
               nxt_r.after = PH_OPC;
            end
            PH_RDAT: begin
               nxt_r.phase = PH_OPC;
            end
            PH_PUSH: begin
               nxt_r.phase = PH_PUSH;
            end
         endcase
      end

      // request leaves only when the queue has room
      if (r_ff.phase == PH_PUSH && q_in_ready) begin
         nxt_r.phase = r_ff.after;
      end

      // inactivity watchdog between host edges
      if (accept) begin
         nxt_r.tmo = 10'h000;
      end else if (busy) begin
         nxt_r.tmo = r_ff.tmo + 10'h001;
      end
      if (busy && !accept && r_ff.tmo == `SWDS_TMO_CYC - 10'h001) begin
         // abandon the transfer and wipe the command register
         nxt_r.tmo = 10'h000;
         nxt_r.phase = PH_OPC;
         nxt_r.bit_st = B_IDLE;
         nxt_r.nbits = 5'h00;
         nxt_r.op = 8'h00;
         nxt_r.shift = 16'h0000;
      end

      // pin drive from the next cycle count; host bits never drive
      nxt_r.oe_n = 1'b1;
      nxt_r.out = 1'b1;
      if (nxt_r.bit_st == B_TX) begin
         if (nxt_r.tx_bit) begin
            nxt_r.oe_n = (nxt_r.cyc != `SWDS_ONE_PULSE);
         end else if (nxt_r.cyc < `SWDS_ZERO_LOW) begin
            nxt_r.oe_n = 1'b0;
            nxt_r.out = 1'b0;
         end else begin
            // one cycle of active high only, then released
            nxt_r.oe_n = 1'b0;
         end
      end

      // a waiting request takes dead cycles first, then steals
      if (!q_out_valid || q_out_ready) begin
         nxt_r.wait_cnt = 8'h00;
      end else if (!steal) begin
         nxt_r.wait_cnt = r_ff.wait_cnt + 8'h01;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         r_ff <= '{sync: 3'h7, bit_st: B_IDLE, phase: PH_OPC, after: PH_OPC,
                   oe_n: 1'b1, out: 1'b1, default: '0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   // depth trades area for how many writes may queue behind a busy cpu
   swds_fifo #(
      .W(`SWDS_Q_WIDTH),
      .D(`SWDS_Q_DEPTH)
   ) u_queue (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_in_valid(r_ff.phase == PH_PUSH),
      .o_in_ready(q_in_ready),
      .i_in_data({r_ff.op, r_ff.addr, r_ff.shift}),
      .o_out_valid(q_out_valid),
      .i_out_ready(q_out_ready),
      .o_out_data(q_out_data)
   );

   // cpu bus side of the queue
   assign steal = (r_ff.wait_cnt == `SWDS_STEAL_CYC);
   assign O_BUS_REQ = q_out_valid & (I_DEAD_CYCLE | steal);
   assign O_BUS_STEAL = q_out_valid & steal & ~I_DEAD_CYCLE;
   assign q_out_ready = O_BUS_REQ & I_BUS_ACK;
   assign O_BUS_OP = q_out_data[39:32];
   assign O_BUS_ADDR = q_out_data[31:16];
   assign O_BUS_DATA = q_out_data[15:0];
   assign O_ENTER_BG = r_ff.enter_bg;
   assign O_ROM_MAP = r_ff.rom_map;
   assign LINK.tgt_out = r_ff.out;
   assign LINK.tgt_oe_n = r_ff.oe_n;
endmodule // swds_target

// *** hw/swds_host.sv ***
`timescale 1ns/1ps
`include "swds_map.svh"
module swds_host (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   swds_if.host LINK,
   input wire logic I_CMD_VALID,
   input wire swds_pkg::swds_op_t I_CMD_OP,
   input wire swds_pkg::swds_word_t I_CMD_ADDR,
   input wire swds_pkg::swds_word_t I_CMD_DATA,
   output logic O_CMD_READY,
   output swds_pkg::swds_word_t O_RD_DATA,
   output logic O_RD_VALID
);
   import swds_pkg::*;

   typedef struct packed {
      logic [1:0] sync;
      swds_host_t st;
      swds_phase_t phase;
      logic [7:0] cyc;
      logic [4:0] nbits;
      swds_op_t op;
      swds_word_t data;
      swds_word_t shift;
      swds_word_t rd;
      logic rd_valid;
      logic out;
      logic oe_n;
   } swds_hst_t;

   swds_hst_t r_ff;
   swds_hst_t nxt_r;
   logic [4:0] need;
   logic [7:0] low_len;

   assign need = (r_ff.phase == PH_OPC) ? `SWDS_OPC_BITS : `SWDS_WORD_BITS;
   // a one releases early, a zero stays low past the target's sample
   assign low_len = r_ff.shift[15] ? `SWDS_H_ONE_LOW : `SWDS_H_ZERO_LOW;

   always_comb begin
      nxt_r = r_ff;
      nxt_r.sync = {r_ff.sync[0], LINK.line};
      nxt_r.rd_valid = 1'b0;
      nxt_r.cyc = r_ff.cyc + 8'h01;
      unique case (r_ff.st)
         H_IDLE: begin
            nxt_r.cyc = 8'h00;
            if (I_CMD_VALID) begin
               nxt_r.op = I_CMD_OP;
               nxt_r.data = I_CMD_DATA;
               nxt_r.shift = {I_CMD_OP, 8'h00};
               nxt_r.phase = PH_OPC;
               nxt_r.nbits = 5'h00;
               nxt_r.st = H_TX;
            end
            // address is parked in data until the opcode has gone out
            if (I_CMD_VALID && I_CMD_OP[`SWDS_OP_HW] && I_CMD_OP[`SWDS_OP_ADDR]) begin
               nxt_r.data = I_CMD_ADDR;
            end
         end
         H_TX: begin
            if (r_ff.cyc == `SWDS_BIT_CYC - 8'h01) begin
               nxt_r.cyc = 8'h00;
               nxt_r.shift = {r_ff.shift[14:0], 1'b0};
               nxt_r.nbits = r_ff.nbits + 5'h01;
               if (r_ff.nbits + 5'h01 == need) begin
                  nxt_r.nbits = 5'h00;
                  nxt_r.st = H_GAP;
                  if (r_ff.phase == PH_OPC && r_ff.op[`SWDS_OP_HW]
                      && r_ff.op[`SWDS_OP_ADDR]) begin
                     nxt_r.phase = PH_ADDR;
                     nxt_r.shift = r_ff.data;
                     nxt_r.data = I_CMD_DATA;
                     nxt_r.st = H_TX;
                  end else if (r_ff.phase == PH_OPC && !r_ff.op[`SWDS_OP_HW]) begin
                     nxt_r.st = H_WAIT;
                  end else if (r_ff.phase == PH_ADDR && r_ff.op[`SWDS_OP_READ]) begin
                     nxt_r.st = H_WAIT;
                  end else if (r_ff.phase == PH_ADDR) begin
                     nxt_r.phase = PH_WDAT;
                     nxt_r.shift = r_ff.data;
                     nxt_r.st = H_TX;
                  end
               end
            end
         end
         H_WAIT: begin
            // let the target finish its bus access first
            if (r_ff.cyc == `SWDS_H_WAIT - 8'h01) begin
               nxt_r.cyc = 8'h00;
               nxt_r.st = H_RX;
            end
         end
         H_RX: begin
            if (r_ff.cyc == `SWDS_H_SAMPLE) begin
               nxt_r.shift = {r_ff.shift[14:0], r_ff.sync[1]};
            end
            if (r_ff.cyc == `SWDS_BIT_CYC - 8'h01) begin
               nxt_r.cyc = 8'h00;
               nxt_r.nbits = r_ff.nbits + 5'h01;
               if (r_ff.nbits == 5'h0f) begin
                  nxt_r.rd = r_ff.shift;
                  nxt_r.rd_valid = 1'b1;
                  nxt_r.st = H_GAP;
               end
            end
         end
         H_GAP: begin
            if (r_ff.cyc == `SWDS_H_WAIT - 8'h01) begin
               nxt_r.st = H_IDLE;
            end
         end
         default: begin
            nxt_r.st = H_IDLE;
         end
      endcase

      // every bit starts with our own falling edge
      nxt_r.oe_n = 1'b1;
      nxt_r.out = 1'b1;
      if (nxt_r.st == H_TX) begin
         if (nxt_r.cyc < low_len) begin
            nxt_r.oe_n = 1'b0;
            nxt_r.out = 1'b0;
         end else if (nxt_r.cyc == low_len) begin
            nxt_r.oe_n = 1'b0;
         end
      end else if (nxt_r.st == H_RX && nxt_r.cyc < `SWDS_H_RX_LOW) begin
         nxt_r.oe_n = 1'b0;
         nxt_r.out = 1'b0;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         r_ff <= '{sync: 2'h3, st: H_IDLE, phase: PH_OPC, oe_n: 1'b1, out: 1'b1,
                   default: '0};
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign O_CMD_READY = (r_ff.st == H_IDLE);
   assign O_RD_DATA = r_ff.rd;
   assign O_RD_VALID = r_ff.rd_valid;
   assign LINK.host_out = r_ff.out;
   assign LINK.host_oe_n = r_ff.oe_n;
endmodule // swds_host

// *** dv/swds_link_assertions.sv ***
`timescale 1ns/1ps
module swds_link_chk (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic tgt_out,
   input wire logic tgt_oe_n,
   input wire logic host_out,
   input wire logic host_oe_n,
   input wire logic line
);
   logic [4:0] gap_ff;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   // cycles since the host pulled the line low, saturating so idle time never wraps
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         gap_ff <= 5'h1f;
      end else if ($fell(line) && !host_oe_n) begin
         gap_ff <= 5'h00;
      end else if (gap_ff != 5'h1f) begin
         gap_ff <= gap_ff + 5'h01;
      end
   end
   a_bit_period: assert property ($fell(line) && !host_oe_n |-> gap_ff >= 5'h0f)
      else $error("host bit start closer than one bit period");
   a_zero_start: assert property ($fell(tgt_oe_n) && !tgt_out |-> gap_ff inside {[1:5]})
      else $error("target zero drive not aligned to host edge");
   a_zero_shape: assert property ($fell(tgt_oe_n) && !tgt_out |->
      (!tgt_oe_n && !tgt_out)[*8] ##1 (!tgt_oe_n && !tgt_out)[*3] ##1 (!tgt_oe_n && tgt_out)
      ##1 tgt_oe_n) else $error("target zero low not ending at cycle thirteen");
   a_one_pulse: assert property ($fell(tgt_oe_n) && tgt_out |-> gap_ff inside {[6:7]})
      else $error("target one pulse not at cycle seven");
   a_host_gone: assert property ($fell(tgt_oe_n) && tgt_out |-> host_oe_n)
      else $error("host still driving at target pulse");
   a_tgt_high_brief: assert property (!tgt_oe_n && tgt_out |=> tgt_oe_n)
      else $error("target high drive longer than one cycle");
   a_host_high_brief: assert property (!host_oe_n && host_out |=> host_oe_n)
      else $error("host high drive longer than one cycle");
   a_host_bit_free: assert property (!host_oe_n && host_out |-> tgt_oe_n)
      else $error("target drives during a host bit");
   a_host_low_hold: assert property ($fell(host_oe_n) |-> (!host_oe_n && !host_out)[*2])
      else $error("host start low shorter than two cycles");
endmodule // swds_link_chk

// *** dv/swds_link_tb_top.sv ***
`timescale 1ns/1ps
module single_wire_debug_serial_tb_top;
   import swds_pkg::*;
   logic clk, rst_n, bg, fw, dead, ack, rd_valid, rd_pend, kick, steal_log;
   logic cmd_valid, cmd_ready, rom_map, enter_bg, req, steal, host_rd_valid, req2;
   swds_op_t cmd_op, bus_op, op2;
   swds_word_t cmd_addr, cmd_data, rd_word, host_rd, bus_addr, bus_data, addr2, data2;
   logic [39:0] log_q;
   logic hold;
   logic [39:0] log_a [4];
   int miscompares, n_compared, pops, n_enter, n, m;
   swds_if i_swds_if();
   swds_if i_swds_if_b();
   swds_target i_swds_target(.I_CLK(clk), .I_RST_N(rst_n), .LINK(i_swds_if),
      .I_BG_ACTIVE(bg), .I_FW_EN(fw), .I_DEAD_CYCLE(dead), .I_BUS_ACK(ack),
      .I_RD_VALID(rd_valid), .I_RD_DATA(rd_word), .O_BUS_REQ(req), .O_BUS_STEAL(steal),
      .O_BUS_OP(bus_op), .O_BUS_ADDR(bus_addr), .O_BUS_DATA(bus_data),
      .O_ENTER_BG(enter_bg), .O_ROM_MAP(rom_map));
   swds_host i_swds_host(.I_CLK(clk), .I_RST_N(rst_n), .LINK(i_swds_if),
      .I_CMD_VALID(cmd_valid), .I_CMD_OP(cmd_op), .I_CMD_ADDR(cmd_addr),
      .I_CMD_DATA(cmd_data), .O_CMD_READY(cmd_ready), .O_RD_DATA(host_rd),
      .O_RD_VALID(host_rd_valid));
   // second target faces a hand-driven host that can stop mid-command
   swds_target i_swds_target_b(.I_CLK(clk), .I_RST_N(rst_n), .LINK(i_swds_if_b),
      .I_BG_ACTIVE(bg), .I_FW_EN(fw), .I_DEAD_CYCLE(dead), .I_BUS_ACK(1'b0),
      .I_RD_VALID(1'b0), .I_RD_DATA(16'h0000), .O_BUS_REQ(req2), .O_BUS_STEAL(),
      .O_BUS_OP(op2), .O_BUS_ADDR(addr2), .O_BUS_DATA(data2), .O_ENTER_BG(), .O_ROM_MAP());
   swds_link_chk i_swds_link_chk(.I_CLK(clk), .I_RST_N(rst_n), .tgt_out(i_swds_if.tgt_out),
      .tgt_oe_n(i_swds_if.tgt_oe_n), .host_out(i_swds_if.host_out),
      .host_oe_n(i_swds_if.host_oe_n), .line(i_swds_if.line));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // bus side: accept every request while hold is low, answer reads one cycle after the pop
   always @(posedge clk) begin
      rd_pend <= req && ack;
      if (req === 1'b1 && ack === 1'b1) begin
         log_q <= {bus_op, bus_addr, bus_data};
         log_a[pops % 4] <= {bus_op, bus_addr, bus_data};
         steal_log <= steal;
         pops <= pops + 1;
      end
      if (enter_bg === 1'b1) n_enter <= n_enter + 1;
   end
   always @(negedge clk) begin
      ack <= req & ~hold;
      rd_valid <= rd_pend | kick;
   end
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one command through the host; returns once the host is idle again
   task automatic cmd(input swds_op_t op, input swds_word_t a, input swds_word_t d);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      @(negedge clk);
      cmd_valid = 1'b0;
      for (int t = 0; t < 3000 && cmd_ready !== 1'b1; t++) @(negedge clk);
   endtask
   // open-drain bit from the hand-driven host, sixteen cycles per bit
   task automatic bb_send(input logic [15:0] v, input int nb);
      for (int k = nb - 1; k >= 0; k--) begin
         @(negedge clk);
         i_swds_if_b.host_oe_n = 1'b0;
         repeat (v[k] ? 4 : 14) @(negedge clk);
         i_swds_if_b.host_oe_n = 1'b1;
         repeat (v[k] ? 11 : 1) @(negedge clk);
      end
   endtask
   initial begin
      rst_n = 1'b0; bg = 1'b0; fw = 1'b0; dead = 1'b1; ack = 1'b0; rd_valid = 1'b0;
      kick = 1'b0; cmd_valid = 1'b0; cmd_op = 8'h00; cmd_addr = 16'h0000;
      cmd_data = 16'h0000; rd_word = 16'h0000; hold = 1'b0;
      i_swds_if_b.host_oe_n = 1'b1; i_swds_if_b.host_out = 1'b0;
      miscompares = 0; n_compared = 0; pops = 0; n_enter = 0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      // four hardware write and four read opcodes, asymmetric values expose bit order
      for (int i = 0; i < 4; i++) begin
         cmd(8'hc0 | 8'(i << 2), 16'h80f1 + 16'(i), 16'h1e5a ^ 16'(i));
         chk(log_q, {8'hc0 | 8'(i << 2), 16'h80f1 + 16'(i), 16'h1e5a ^ 16'(i)});
         chk(40'(steal_log), 40'h0);
         rd_word = 16'hc3a5 + 16'(i);
         cmd(8'he0 | 8'(i << 2), 16'h4002 + 16'(i), 16'h0000);
         chk(40'(log_q[39:16]), 40'({8'he0 | 8'(i << 2), 16'h4002 + 16'(i)}));
         chk(40'(host_rd), 40'(16'hc3a5 + 16'(i)));
      end
      // no dead cycles: the access must steal
      dead = 1'b0;
      cmd(8'hc8, 16'h0102, 16'hfe01);
      chk(log_q, {8'hc8, 16'h0102, 16'hfe01});
      chk(40'(steal_log), 40'h1);
      dead = 1'b1;
      n = n_enter;
      cmd(8'h90, 16'h0000, 16'h0000);
      chk(40'(n_enter), 40'(n));
      fw = 1'b1;
      cmd(8'h90, 16'h0000, 16'h0000);
      chk(40'(n_enter), 40'(n + 1));
      // firmware opcode is dropped outside background mode, line stays pulled up
      m = pops;
      cmd(8'h62, 16'h0000, 16'h0000);
      chk(40'(pops), 40'(m));
      chk(40'(host_rd), 40'hffff);
      // the target took our receive starts as an opcode and half an address; let its timeout clear them
      repeat (600) @(negedge clk);
      bg = 1'b1;
      rd_word = 16'h5a0f;
      @(posedge clk) kick <= 1'b1;
      @(posedge clk) kick <= 1'b0;
      chk(40'(rom_map), 40'h1);
      cmd(8'h64, 16'h0000, 16'h0000);
      chk(40'(host_rd), 40'h5a0f);
      bg = 1'b0;
      repeat (3) @(negedge clk);
      chk(40'(rom_map), 40'h0);
      // half an opcode, then silence past the timeout, then a whole write
      bb_send(16'h000f, 4);
      repeat (600) @(negedge clk);
      bb_send(16'h00c0, 8);
      bb_send(16'h0ff0, 16);
      bb_send(16'h3c3c, 16);
      repeat (20) @(negedge clk);
      chk(40'(req2), 40'h1);
      chk({op2, addr2, data2}, {8'hc0, 16'h0ff0, 16'h3c3c});
      // stall the bus: three writes wait in the queue, then leave in order
      hold = 1'b1;
      m = pops;
      for (int i = 0; i < 3; i++) begin
         cmd(8'hc4, 16'h2000 + 16'(i), 16'h7e81 ^ 16'(i));
      end
      chk(40'(pops), 40'(m));
      chk(40'(req), 40'h1);
      hold = 1'b0;
      repeat (8) @(negedge clk);
      for (int i = 0; i < 3; i++) begin
         chk(log_a[(m + i) % 4], {8'hc4, 16'h2000 + 16'(i), 16'h7e81 ^ 16'(i)});
      end
      chk(40'(pops), 40'(m + 3));
      chk(40'(req), 40'h0);
      wrap_up();
   end
   // the whole run is about 14000 cycles, so this only trips on a hang
   initial begin
      #400000;
      miscompares++;
      wrap_up();
   end
endmodule // single_wire_debug_serial_tb_top
